// [logic/uart_rx_recog.sv]
// receiver, frame recognition, loopback and tx tristate of a low energy uart, apb slave
// What this block does
// - frame parked for lack of space still enters the buffer later, blocked or not
// - overwriting a waiting frame sets the overflow flag, even while blocked
// - one sample per bit, near the bit middle, start bit included
// - bit period is 1 + divider/256 slow clock periods
// - bit n sampled at floor(n*(1+div/256)+div/512) slow edges after start
// - start bit sampled high abandons the frame and rearms
// - parity checked when enabled; mismatch sets frame bit and flag
// - frames with parity errors are buffered like good ones
// - stop bit sampled low is a framing error, flagged, frame still buffered
// - framing bit readable via extended and peek reads, parity via extended read
// - enabled and blocked: frames received, all but address frames and unblocking start frames discarded
// - start frame with unblock enabled clears block and is buffered
// - every start frame sets the start frame flag
// - 8 data bits compare low 8 bits, 9 bits compare all
// - start frames detected only when enabled and error free
// - enabled receiver matching the signal frame sets the signal flag
// - erroneous frame is never a signal frame
// - multiprocessor address frame sets its flag and is buffered even blocked
// - erroneous frame is never an address frame
// - loopback feeds the receiver from the transmit pin
// - auto tristate releases the transmit pin while the transmitter is idle
// - block flag set and cleared by block on and block off commands
// - blocked erroneous frames are dropped without recognition or any flag but overflow
// - new frame with buffer and shift register full overwrites and flags overflow
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module uart_rx_recog
   import uart_rx_pkg::*;
(
   input wire logic pclk, // bus clock, 200 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [11:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic low_freq_clock, // 32.768 kHz clock, sampled
   input wire logic rx_pin, // receive pin
   input wire logic tx_pin_i, // transmit pin level seen on the wire
   output logic tx_pin_o, // transmit pin drive value
   output logic tx_pin_oe, // transmit pin output enable, high drives
   input wire logic tx_data, // serial data from the transmitter
   input wire logic tx_active // transmitter busy
);
   // synchronisers: first stage read only by the second
   logic lf_s1, lf_s2, lf_s3;
   logic rx_s1, rx_s2, txp_s1, txp_s2;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_s1 <= 1'b0;
         lf_s2 <= 1'b0;
         lf_s3 <= 1'b0;
         rx_s1 <= 1'b1;
         rx_s2 <= 1'b1;
         txp_s1 <= 1'b1;
         txp_s2 <= 1'b1;
      end else begin
         lf_s1 <= low_freq_clock;
         lf_s2 <= lf_s1;
         lf_s3 <= lf_s2;
         rx_s1 <= rx_pin;
         rx_s2 <= rx_s1;
         txp_s1 <= tx_pin_i;
         txp_s2 <= txp_s1;
      end
   end

   // registers
   logic [10:0] ctrl;
   logic [DIV_WIDTH-1:0] baud_divider_value;
   logic [8:0] start_frame_value;
   logic [8:0] signal_frame_value;
   logic rx_enabled_status;
   logic rx_blocked;
   logic [FLAG_COUNT-1:0] flags;
   frame_entry_s rx_buf, shift_hold;
   logic buf_valid, hold_valid;

   wire auto_tristate_en = ctrl[CTRL_AUTO_TRI];
   wire nine_bits = ctrl[CTRL_NINE_BITS];
   wire [1:0] parity_mode = ctrl[CTRL_PARITY_LO +: 2];
   wire parity_on = parity_mode[1];
   wire two_stop = ctrl[CTRL_TWO_STOP];
   wire loopback_en = ctrl[CTRL_LOOPBACK];
   wire start_frame_unblock_en = ctrl[CTRL_SF_UNBLOCK];
   wire multiproc_mode_en = ctrl[CTRL_MULTIPROC];
   wire address_bit_value = ctrl[CTRL_ADDR_BIT];

   // slow clock rising edge; all receive timing advances on it
   wire tick = lf_s2 & ~lf_s3;
   wire line = loopback_en ? txp_s2 : rx_s2;

   // apb decode
   wire setup = psel & ~penable;
   wire access = psel & penable & pready;
   wire wr = access & pwrite;
   wire hit_ctrl = (paddr == ADDR_CTRL);
   wire hit_cmd = (paddr == ADDR_CMD);
   wire hit_status = (paddr == ADDR_STATUS);
   wire hit_div = (paddr == ADDR_DIV);
   wire hit_sf = (paddr == ADDR_START_FRAME);
   wire hit_sig = (paddr == ADDR_SIG_FRAME);
   wire hit_rxx = (paddr == ADDR_RX_DATA_EXT);
   wire hit_rx = (paddr == ADDR_RX_DATA);
   wire hit_peek = (paddr == ADDR_RX_PEEK);
   wire hit_flags = (paddr == ADDR_FLAGS);
   wire hit_fclr = (paddr == ADDR_FLAGS_CLR);
   wire mapped = hit_ctrl | hit_cmd | hit_status | hit_div | hit_sf | hit_sig | hit_rxx
      | hit_rx | hit_peek | hit_flags | hit_fclr;
   wire cmd_wr = wr & hit_cmd;
   wire cmd_rx_on = cmd_wr & pwdata[CMD_RX_ON];
   wire cmd_rx_off = cmd_wr & pwdata[CMD_RX_OFF];
   wire block_on_cmd = cmd_wr & pwdata[CMD_BLOCK_ON];
   wire block_off_cmd = cmd_wr & pwdata[CMD_BLOCK_OFF];
   wire [FLAG_COUNT-1:0] flag_clr = (wr & hit_fclr) ? pwdata[FLAG_COUNT-1:0] : '0;

   // removing reads: buffer state is latched at setup so the access edge pops what was read
   logic pop_armed, pop_empty;
   wire pop_read = access & ~pwrite & (hit_rxx | hit_rx);
   wire pop = pop_read & pop_armed;
   wire underflow = pop_read & pop_empty;

   // entry views
   wire [31:0] entry_word = {16'h0000, rx_buf.framing, rx_buf.parity, 5'h00, rx_buf.data};
   wire [31:0] peek_word = {16'h0000, rx_buf.framing, 6'h00, rx_buf.data};
   wire [31:0] status_word = {29'h0, buf_valid, rx_blocked, rx_enabled_status};
   wire [31:0] read_mux =
      hit_ctrl ? {21'h0, ctrl} :
      hit_status ? status_word :
      hit_div ? {17'h0, baud_divider_value} :
      hit_sf ? {23'h0, start_frame_value} :
      hit_sig ? {23'h0, signal_frame_value} :
      hit_rxx ? entry_word :
      hit_rx ? {24'h0, rx_buf.data[7:0]} :
      hit_peek ? peek_word :
      hit_flags ? {25'h0, flags} : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         pop_armed <= 1'b0;
         pop_empty <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup & ~mapped;
         prdata <= setup & ~pwrite ? read_mux : 32'h0000_0000;
         pop_armed <= setup & buf_valid;
         pop_empty <= setup & ~buf_valid;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= 11'h000;
         baud_divider_value <= {RESET_DIV, 3'h0};
         start_frame_value <= 9'h000;
         signal_frame_value <= 9'h000;
      end else if (wr) begin
         if (hit_ctrl) ctrl <= pwdata[10:0] & CTRL_MASK;
         if (hit_div) baud_divider_value <= pwdata[DIV_WIDTH-1:0];
         if (hit_sf) start_frame_value <= pwdata[8:0];
         if (hit_sig) signal_frame_value <= pwdata[8:0];
      end
   end

   // bit timing: target = n*(512 + 2*div) + div, sample on slow edge floor(target/512)
   wire [ACC_WIDTH-1:0] div_ext = {{(ACC_WIDTH-DIV_WIDTH){1'b0}}, baud_divider_value};
   wire [ACC_WIDTH-1:0] step = ACC_ONE_BIT + (div_ext << 1);
   wire [11:0] first_edge = div_ext[ACC_WIDTH-1:ACC_FRAC];

   rx_state_e state;
   logic [ACC_WIDTH-1:0] target;
   logic [11:0] edges;
   logic [3:0] bit_idx;
   // index 12 is the second stop bit of a nine bit frame with parity
   logic [12:0] bits;

   wire [3:0] data_len = nine_bits ? 4'd9 : 4'd8;
   wire [3:0] stop_pos = data_len + {3'b000, parity_on} + 4'd1;
   wire [3:0] last_pos = stop_pos + {3'b000, two_stop};
   wire [11:0] next_edges = edges + 12'd1;
   wire sample_now = tick & (next_edges == target[ACC_WIDTH-1:ACC_FRAC]);
   wire start_seen = tick & ~line & rx_enabled_status;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         target <= '0;
         edges <= 12'h000;
         bit_idx <= 4'h0;
         bits <= 13'h0000;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_seen && !cmd_rx_off) begin
                  // edge 0; when div < 512 the start bit is sampled on this very edge
                  state <= ST_RECV;
                  edges <= 12'h000;
                  bits <= 13'h0000;
                  if (first_edge == 12'h000) begin
                     bit_idx <= 4'h1;
                     target <= div_ext + step;
                  end else begin
                     bit_idx <= 4'h0;
                     target <= div_ext;
                  end
               end
            end
            ST_RECV: begin
               if (cmd_rx_off || !rx_enabled_status) begin
                  state <= ST_IDLE;
               end else if (tick) begin
                  edges <= next_edges;
                  if (sample_now) begin
                     target <= target + step;
                     bit_idx <= bit_idx + 4'h1;
                     bits[bit_idx] <= line;
                     if (bit_idx == 4'h0 && line) begin
                        state <= ST_IDLE;
                     end else if (bit_idx == last_pos) begin
                        state <= ST_DONE;
                     end
                  end
               end
            end
            ST_DONE: begin
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // frame evaluation, valid in ST_DONE
   wire [8:0] rx_word = nine_bits ? bits[9:1] : {1'b0, bits[8:1]};
   wire par_bit = bits[data_len + 4'd1];
   wire par_calc = ^rx_word;
   wire parity_error = parity_on & ((par_calc ^ par_bit) ^ (parity_mode == PARITY_ODD));
   wire framing_error = ~bits[stop_pos] | (two_stop & ~bits[last_pos]);
   wire frame_bad = parity_error | framing_error;
   wire done = (state == ST_DONE);
   wire drop_silent = rx_blocked & frame_bad;
   wire keep = done & ~drop_silent;
   wire sf_match = nine_bits ? (rx_word == start_frame_value)
      : (rx_word[7:0] == start_frame_value[7:0]);
   wire sig_match = nine_bits ? (rx_word == signal_frame_value)
      : (rx_word[7:0] == signal_frame_value[7:0]);
   wire is_start = keep & ~frame_bad & rx_enabled_status & sf_match;
   wire is_signal = keep & ~frame_bad & rx_enabled_status & sig_match;
   wire is_addr = keep & ~frame_bad & multiproc_mode_en & nine_bits
      & (rx_word[8] == address_bit_value);
   wire unblock = is_start & start_frame_unblock_en;
   // error frames kept while unblocked; when blocked, only error free address frames and unblocking start frames
   wire load = keep & (~rx_blocked | unblock | is_addr);
   wire overwrite = done & hold_valid & buf_valid;

   frame_entry_s new_entry;
   assign new_entry = '{framing: framing_error, parity: parity_error, data: rx_word};

   // the hold slot is the shift register; it drains whenever the buffer has room
   wire hold_to_buf = hold_valid & (~buf_valid | pop);
   logic [FLAG_COUNT-1:0] flag_set;

   always_comb begin
      flag_set = '0;
      flag_set[FLAG_OVERFLOW] = overwrite;
      flag_set[FLAG_UNDERFLOW] = underflow;
      flag_set[FLAG_PARITY] = keep & parity_error;
      flag_set[FLAG_FRAMING] = keep & framing_error;
      flag_set[FLAG_ADDRESS] = is_addr;
      flag_set[FLAG_START] = is_start;
      flag_set[FLAG_SIGNAL] = is_signal;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= '0;
      end else begin
         flags <= (flags & ~flag_clr) | flag_set; // set beats a simultaneous clear
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_enabled_status <= 1'b0;
         rx_blocked <= 1'b0;
      end else begin
         if (cmd_rx_off) rx_enabled_status <= 1'b0;
         else if (cmd_rx_on) rx_enabled_status <= 1'b1;
         // software command outranks an unblock by a start frame in the same cycle
         if (block_on_cmd) rx_blocked <= 1'b1;
         else if (block_off_cmd || unblock) rx_blocked <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_valid <= 1'b0;
         hold_valid <= 1'b0;
         rx_buf <= '0;
         shift_hold <= '0;
      end else begin
         if (hold_to_buf) begin
            rx_buf <= shift_hold;
            buf_valid <= 1'b1;
         end else if (pop) begin
            buf_valid <= 1'b0;
         end
         if (done && (load || overwrite)) begin
            // a waiting frame is replaced; a discarded newcomer leaves the slot empty
            shift_hold <= new_entry;
            hold_valid <= load;
         end else if (hold_to_buf) begin
            hold_valid <= 1'b0;
         end
      end
   end

   // transmit pin: released while idle under auto tristate; the far side avoids collisions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_pin_o <= 1'b1;
         tx_pin_oe <= 1'b1;
      end else begin
         tx_pin_o <= tx_data;
         tx_pin_oe <= ~auto_tristate_en | tx_active;
      end
   end
endmodule

`default_nettype wire

// [include/uart_rx_pkg.sv]
// constants, register map and frame layout of the low energy uart receiver
package uart_rx_pkg;
   // register byte addresses
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_CMD = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_DIV = 12'h00C;
   localparam logic [11:0] ADDR_START_FRAME = 12'h010;
   localparam logic [11:0] ADDR_SIG_FRAME = 12'h014;
   localparam logic [11:0] ADDR_RX_DATA_EXT = 12'h018;
   localparam logic [11:0] ADDR_RX_DATA = 12'h01C;
   localparam logic [11:0] ADDR_RX_PEEK = 12'h020;
   localparam logic [11:0] ADDR_FLAGS = 12'h02C;
   localparam logic [11:0] ADDR_FLAGS_CLR = 12'h034;
   // control fields
   localparam int CTRL_AUTO_TRI = 0;
   localparam int CTRL_NINE_BITS = 1;
   localparam int CTRL_PARITY_LO = 2;
   localparam int CTRL_TWO_STOP = 4;
   localparam int CTRL_LOOPBACK = 7;
   localparam int CTRL_SF_UNBLOCK = 8;
   localparam int CTRL_MULTIPROC = 9;
   localparam int CTRL_ADDR_BIT = 10;
   localparam logic [10:0] CTRL_MASK = 11'h79F;
   localparam logic [1:0] PARITY_EVEN = 2'h2;
   localparam logic [1:0] PARITY_ODD = 2'h3;
   // command fields
   localparam int CMD_RX_ON = 0;
   localparam int CMD_RX_OFF = 1;
   localparam int CMD_BLOCK_ON = 2;
   localparam int CMD_BLOCK_OFF = 3;
   // status fields
   localparam int STAT_RX_ENABLED = 0;
   localparam int STAT_RX_BLOCKED = 1;
   localparam int STAT_DATA_VALID = 2;
   // sticky flag fields
   localparam int FLAG_OVERFLOW = 0;
   localparam int FLAG_UNDERFLOW = 1;
   localparam int FLAG_PARITY = 2;
   localparam int FLAG_FRAMING = 3;
   localparam int FLAG_ADDRESS = 4;
   localparam int FLAG_START = 5;
   localparam int FLAG_SIGNAL = 6;
   localparam int FLAG_COUNT = 7;
   // frame entry fields in extended reads
   localparam int RXD_PARITY = 14;
   localparam int RXD_FRAMING = 15;
   // baud timing: one bit is 1 + div/256 slow clock periods; target kept in 1/512 units
   localparam int DIV_WIDTH = 15;
   localparam int ACC_WIDTH = 21;
   localparam int ACC_FRAC = 9;
   localparam logic [ACC_WIDTH-1:0] ACC_ONE_BIT = 21'h000200;
   localparam logic [11:0] RESET_DIV = 12'h000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01,
      ST_DONE = 2'b11
   } rx_state_e;

   typedef struct packed {
      logic framing;
      logic parity;
      logic [8:0] data;
   } frame_entry_s;
endpackage

// [verif/uart_rx_recog_props.sv]
// assertions on the receiver's bus answers and transmit pin
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recog_props
   import uart_rx_pkg::*;
(
   input wire logic pclk, // bus clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // direction
   input wire logic [11:0] paddr, // address
   input wire logic [31:0] pwdata, // write data
   input wire logic [31:0] prdata, // read data
   input wire logic pready, // ready
   input wire logic pslverr, // error
   input wire logic low_freq_clock, // slow clock
   input wire logic rx_pin, // receive pin
   input wire logic tx_pin_i, // transmit wire level
   input wire logic tx_pin_o, // transmit drive value
   input wire logic tx_pin_oe, // transmit enable
   input wire logic tx_data, // transmitter data
   input wire logic tx_active // transmitter busy
);
   logic auto_tri, blk_exp, blk_valid;
   wire acc = psel && penable && pready;
   wire ctrl_wr = acc && pwrite && paddr == ADDR_CTRL;
   wire cmd_blk = acc && pwrite && paddr == ADDR_CMD
      && (pwdata[CMD_BLOCK_ON] || pwdata[CMD_BLOCK_OFF]);
   wire rd_acc = pready && !pwrite;
   // shadow of the tristate bit and of the last block command, snooped off the bus
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_tri <= 1'b0;
         blk_exp <= 1'b0;
         blk_valid <= 1'b0;
      end else begin
         if (ctrl_wr) auto_tri <= pwdata[CTRL_AUTO_TRI];
         if (acc) blk_valid <= cmd_blk;
         if (cmd_blk) blk_exp <= pwdata[CMD_BLOCK_ON];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_OE_FOLLOW: assert property (
      tx_pin_oe == (!$past(auto_tri) || $past(tx_active)))
      else $error("transmit enable does not follow tristate setting");
   AST_OE_IDLE: assert property ((auto_tri && !tx_active) [*2] |-> !tx_pin_oe)
      else $error("idle transmitter still drives the pin");
   AST_TX_COPY: assert property ($past(presetn) |-> tx_pin_o == $past(tx_data))
      else $error("transmit pin does not carry transmitter data");
   AST_ANSWER_NEXT: assert property (psel && !penable |=> pready)
      else $error("no answer in the access cycle");
   AST_ONE_CYCLE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer without ready or with data");
   AST_PEEK_FIELDS: assert property (
      rd_acc && paddr == ADDR_RX_PEEK |-> (prdata & 32'hFFFF7E00) == 32'h0)
      else $error("peek read shows bits outside data and framing");
   AST_EXT_FIELDS: assert property (
      rd_acc && paddr == ADDR_RX_DATA_EXT |-> (prdata & 32'hFFFF3E00) == 32'h0)
      else $error("extended read shows bits outside the frame entry");
   AST_BLOCK_CMD: assert property (
      rd_acc && paddr == ADDR_STATUS && blk_valid |-> prdata[STAT_RX_BLOCKED] == blk_exp)
      else $error("block status does not follow the last block command");
endmodule
bind uart_rx_recog uart_rx_recog_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .low_freq_clock(low_freq_clock), .rx_pin(rx_pin),
   .tx_pin_i(tx_pin_i), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_data(tx_data),
   .tx_active(tx_active));
`default_nettype wire

// [verif/remote_uart_dev.sv]
// remote serial sender: changes the line on falling slow edges, idles high
`timescale 1ns/1ps
`default_nettype none
module remote_uart_dev (
   input wire logic low_freq_clock, // slow bit clock
   output logic line // serial line
);
   initial line = 1'b1;
   function automatic int samp(input int n, input int d);
      return (n * (256 + d) * 2 + d) / 512;
   endfunction
   // each bit stands from just after the previous sample up to its own one
   task automatic send(input logic [12:0] bits, input int nb, input int d);
      int t;
      t = 0;
      @(negedge low_freq_clock) line = bits[0];
      @(posedge low_freq_clock);
      for (int n = 1; n <= nb; n++) begin
         while (t < samp(n - 1, d)) begin
            @(posedge low_freq_clock);
            t++;
         end
         @(negedge low_freq_clock) line = (n == nb) ? 1'b1 : bits[n];
      end
      @(posedge low_freq_clock);
   endtask
   // low for one slow period only, so a late start check sees high
   task automatic glitch;
      @(negedge low_freq_clock) line = 1'b0;
      @(negedge low_freq_clock) line = 1'b1;
      repeat (4) @(posedge low_freq_clock);
   endtask
endmodule
`default_nettype wire

// [verif/uart_rx_recog_tb_top.sv]
// self-checking bench for the uart receiver with frame recognition
`timescale 1ns/1ps
`default_nettype none
module uart_rx_recog_tb_top;
   import uart_rx_pkg::*;
   localparam int LIMIT = 60000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lfclk, line, rx_pin;
   logic tx_active, loop_mode, tx_data, tx_pin_i, tx_pin_o, tx_pin_oe;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [10:0] ctrl;
   logic [8:0] dat;
   logic [11:0] rst_regs [5] = '{ADDR_CTRL, ADDR_STATUS, ADDR_DIV, ADDR_FLAGS, 12'h03C};
   int div, seed, error_cnt, compares, cycles;
   assign rx_pin = loop_mode ? ~line : line;
   assign tx_data = loop_mode ? line : 1'b1;
   assign tx_pin_i = tx_pin_oe ? tx_pin_o : 1'b1; // pulled up when released
   uart_rx_recog i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_freq_clock(lfclk), .rx_pin(rx_pin), .tx_pin_i(tx_pin_i),
      .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_data(tx_data), .tx_active(tx_active));
   remote_uart_dev i_remote (.low_freq_clock(lfclk), .line(line));
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // slow clock far above its real rate so frames fit a short run
   initial begin
      lfclk = 1'b0;
      #13;
      forever #50 lfclk = ~lfclk;
   end
   task automatic give_verdict;
      $display("compares %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         error_cnt++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      if (a == ADDR_CTRL) ctrl = d[10:0];
      if (a == ADDR_DIV) div = int'(d[14:0]);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic fl(input logic [31:0] e);
      rc(ADDR_FLAGS, e);
      wr(ADDR_FLAGS_CLR, 32'h7F);
   endtask
   function automatic logic [31:0] ext(input logic [8:0] d, input logic bp, input logic bs);
      return {16'h0, bs, bp, 5'h0, d & (ctrl[CTRL_NINE_BITS] ? 9'h1FF : 9'h0FF)};
   endfunction
   // frame as the remote party sends it; bp spoils parity, bs zeroes the first stop bit
   task automatic fr(input logic [8:0] d, input logic bp, input logic bs);
      logic [12:0] b;
      int k;
      b = '1;
      b[0] = 1'b0;
      for (k = 1; k <= (ctrl[CTRL_NINE_BITS] ? 9 : 8); k++) b[k] = d[k - 1];
      if (ctrl[3]) begin
         b[k] = ^ext(d, 1'b0, 1'b0) ^ ctrl[2] ^ bp;
         k++;
      end
      b[k] = ~bs;
      i_remote.send(b, k + (ctrl[CTRL_TWO_STOP] ? 2 : 1), div);
   endtask
   initial begin
      seed = 74;
      {presetn, psel, penable, pwrite, tx_active, loop_mode} = '0;
      paddr = '0;
      pwdata = '0;
      ctrl = '0;
      div = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_regs[i]) rc(rst_regs[i], 32'h0);
      chk({31'h0, tx_pin_oe}, 32'h1);
      wr(ADDR_CMD, 32'h1);
      for (int i = 0; i < 8; i++) begin
         wr(ADDR_CTRL, 32'($random(seed)) & 32'h1E);
         wr(ADDR_DIV, i == 0 ? 32'h0 : 32'($random(seed)) & 32'h3FF);
         dat = 9'($random(seed));
         fr(dat, 1'b0, 1'b0);
         rc(ADDR_RX_PEEK, ext(dat, 1'b0, 1'b0));
         rc(ADDR_RX_DATA_EXT, ext(dat, 1'b0, 1'b0));
      end
      wr(ADDR_CTRL, 32'h8);
      wr(ADDR_DIV, 32'h12C);
      fr(9'h5A, 1'b1, 1'b0);
      rc(ADDR_FLAGS, 32'h4);
      rc(ADDR_RX_DATA_EXT, ext(9'h5A, 1'b1, 1'b0));
      fr(9'hC3, 1'b0, 1'b1);
      rc(ADDR_RX_PEEK, 32'h80C3);
      rc(ADDR_RX_DATA_EXT, ext(9'hC3, 1'b0, 1'b1));
      fl(32'hC);
      wr(ADDR_CTRL, 32'h0);
      fr(9'h11, 1'b0, 1'b0);
      fr(9'h22, 1'b0, 1'b0);
      fr(9'h33, 1'b0, 1'b0);
      fl(32'h1);
      rc(ADDR_RX_DATA, 32'h11);
      fr(9'h44, 1'b0, 1'b0);
      wr(ADDR_CMD, 32'h4);
      rc(ADDR_STATUS, 32'h7);
      rc(ADDR_RX_DATA, 32'h33);
      rc(ADDR_RX_DATA, 32'h44);
      wr(ADDR_CMD, 32'h8);
      fr(9'h66, 1'b0, 1'b0);
      fr(9'h77, 1'b0, 1'b0);
      wr(ADDR_CMD, 32'h4);
      fr(9'h88, 1'b0, 1'b0);
      rc(ADDR_FLAGS, 32'h1);
      rc(ADDR_RX_DATA, 32'h66);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      wr(ADDR_FLAGS_CLR, 32'h7F);
      wr(ADDR_START_FRAME, 32'h13C);
      wr(ADDR_SIG_FRAME, 32'hA5);
      wr(ADDR_CTRL, 32'h100);
      fr(9'h05, 1'b0, 1'b0);
      rc(ADDR_STATUS, 32'h3);
      fr(9'h3C, 1'b0, 1'b0);
      fl(32'h20);
      rc(ADDR_STATUS, 32'h5);
      rc(ADDR_RX_DATA, 32'h3C);
      fr(9'hA5, 1'b0, 1'b0);
      fl(32'h40);
      rc(ADDR_RX_DATA, 32'hA5);
      wr(ADDR_CTRL, 32'h108);
      fr(9'hA5, 1'b1, 1'b0);
      fl(32'h4);
      rc(ADDR_RX_DATA, 32'hA5);
      fr(9'h3C, 1'b1, 1'b0);
      fl(32'h4);
      rc(ADDR_RX_DATA, 32'h3C);
      wr(ADDR_CMD, 32'h4);
      fr(9'h3C, 1'b1, 1'b0);
      fl(32'h0);
      rc(ADDR_STATUS, 32'h3);
      wr(ADDR_CTRL, 32'h2);
      fr(9'h03C, 1'b0, 1'b0);
      fl(32'h0);
      fr(9'h13C, 1'b0, 1'b0);
      fl(32'h20);
      rc(ADDR_STATUS, 32'h3);
      wr(ADDR_CTRL, 32'h60A);
      fr(9'h142, 1'b1, 1'b0);
      fl(32'h0);
      fr(9'h142, 1'b0, 1'b0);
      fl(32'h10);
      rc(ADDR_RX_DATA_EXT, 32'h142);
      wr(ADDR_CMD, 32'h8);
      fr(9'h142, 1'b1, 1'b0);
      fl(32'h4);
      rc(ADDR_RX_DATA_EXT, ext(9'h142, 1'b1, 1'b0));
      wr(ADDR_CMD, 32'h2);
      fr(9'h13C, 1'b0, 1'b0);
      fl(32'h0);
      wr(ADDR_CMD, 32'h1);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_DIV, 32'h200);
      i_remote.glitch();
      rc(ADDR_STATUS, 32'h1);
      fr(9'h5A, 1'b0, 1'b0);
      rc(ADDR_RX_DATA, 32'h5A);
      // receive pin carries the inverse, so only the transmit pin yields the frame
      wr(ADDR_CTRL, 32'h80);
      tx_active <= 1'b1;
      loop_mode <= 1'b1;
      fr(9'h96, 1'b0, 1'b0);
      rc(ADDR_RX_DATA, 32'h96);
      loop_mode <= 1'b0;
      wr(ADDR_CTRL, 32'h1);
      tx_active <= 1'b0;
      repeat (3) @(posedge pclk);
      chk({31'h0, tx_pin_oe}, 32'h0);
      tx_active <= 1'b1;
      repeat (3) @(posedge pclk);
      chk({31'h0, tx_pin_oe}, 32'h1);
      give_verdict();
   end
endmodule
`default_nettype wire
